//--- hw/srh_status.v
// status reporting hierarchy: two generic registers, event byte, summary byte
// Behaviour
// R1: generic register has five 16-bit parts
// R2: bit 15 of every part reads zero
// R3: one source, one bit position, all parts
// R4: live state read-only, no read side effect
// R5: rising edge latches when rise filter set
// R6: falling edge latches when fall filter set
// R7: filters and enable mask are read/write
// R8: latched events clear on read, not writable
// R9: summary is OR of event AND enable
// R10: summary feeds live state one level up
// R11: byte bit 6 summarises enabled other bits
// R12: byte readable by query and serial poll
// R13: request mask bit 6 ignored
// R14: masked rising byte bit raises request
// R15: request mask written and read back
// R16: byte bit 2 set on error entry
// R17: byte bit 3 is questionable summary
// R18: message available follows output queue
// R19: error queue returns oldest entry first
// R20: event enable masks standard event register
// R21: byte bit 4 while message waits
// R22: byte bit 5 is standard event summary
// R23: byte bit 7 is operation summary
// R24: event coinciding with clear stays latched
// R25: byte bits 0 and 1 read zero
`timescale 1ns/10ps
`include "srh_defines.vh"

module srh_status #(
	parameter EQ_DEPTH = 8,
	parameter EQ_AW = 3,
	parameter EQ_DW = 16
) (
	// clock, reset, enable
	input wire clk,
	input wire rstn,
	input wire ce,
	// live sources of the two generic registers
	input wire [14:0] questionable_summary_src,
	input wire [14:0] operation_summary_src,
	// standard events, one-cycle pulses
	input wire [7:0] std_evt,
	// output queue and error queue feeding
	input wire out_q_avail,
	input wire err_push,
	input wire [EQ_DW-1:0] err_code,
	// command port from the remote parser
	input wire cmd_wr,
	input wire cmd_rd,
	input wire [`SRH_SEL_W-1:0] cmd_sel,
	input wire [15:0] cmd_wdata,
	output reg [15:0] cmd_rdata,
	output reg cmd_rvalid,
	// serial poll and service request
	input wire spoll,
	output reg [7:0] spoll_byte,
	output reg spoll_valid,
	output reg srq,
	output wire err_q_nonempty
);

	// generic register parts, questionable and operation; see R1
	reg [15:0] q_prev_r, q_rise_r, q_fall_r, q_evt_r, q_ena_r;
	reg [15:0] o_prev_r, o_rise_r, o_fall_r, o_evt_r, o_ena_r;
	// standard event register and its enable
	reg [7:0] esr_r, ese_r;
	// request mask and service request state
	reg [7:0] sre_r;
	reg [7:0] stb_prev_r;
	// error queue storage and pointers
	reg [EQ_DW-1:0] eq_mem [0:EQ_DEPTH-1];
	reg [EQ_AW-1:0] eq_wp_r, eq_rp_r;
	reg [EQ_AW:0] eq_cnt_r;

	// latched events: new filtered edges, cleared on read unless fresh
	function [15:0] srh_evt_nxt;
		input [15:0] cur, prev, rise, fall, evt;
		input clr;
		reg [15:0] hit;
		begin
			hit = (cur & ~prev & rise) | (~cur & prev & fall); // see R5 R6
			srh_evt_nxt = ((clr ? 16'h0000 : evt) | hit) & `SRH_MASK15; // see R24
		end
	endfunction

	// summary bit of one generic register
	function srh_sum;
		input [15:0] evt, ena;
		begin
			srh_sum = |(evt & ena & `SRH_MASK15); // see R9
		end
	endfunction

	// live state parts; bit 15 forced low, nothing can write them
	wire [15:0] q_cond = {1'b0, questionable_summary_src}; // see R2 R4
	wire [15:0] o_cond = {1'b0, operation_summary_src}; // see R2 R4
	wire questionable_summary_sum = srh_sum(q_evt_r, q_ena_r); // see R10
	wire operation_summary_sum = srh_sum(o_evt_r, o_ena_r); // see R10
	wire esb_sum = |(esr_r & ese_r); // see R20 R22
	wire eq_empty = (eq_cnt_r == {(EQ_AW+1){1'b0}});
	wire eq_full = (eq_cnt_r == EQ_DEPTH[EQ_AW:0]);
	assign err_q_nonempty = ~eq_empty;

	// low bits of byte, without request summary
	wire [7:0] stb_low;
	assign stb_low[0] = 1'b0; // see R25
	assign stb_low[1] = 1'b0; // see R25
	assign stb_low[`SRH_B_ERR] = ~eq_empty; // see R16
	assign stb_low[`SRH_B_QUESTIONABLE_SUMMARY] = questionable_summary_sum; // see R17
	assign stb_low[`SRH_B_MAV] = out_q_avail; // see R18 R21
	assign stb_low[`SRH_B_ESB] = esb_sum; // see R22
	assign stb_low[`SRH_B_RQS] = 1'b0;
	assign stb_low[`SRH_B_OPERATION_SUMMARY] = operation_summary_sum; // see R23
	// mask bit 6 of the request mask has no effect
	wire [7:0] sre_eff = sre_r & ~(8'h01 << `SRH_B_RQS); // see R13
	wire rqs = |(stb_low & sre_eff); // see R11
	wire [7:0] stb_full = stb_low | ({7'h00, rqs} << `SRH_B_RQS);

	// decoded command strobes
	wire rd_qevt = cmd_rd && cmd_sel == `SRH_SEL_QEVT;
	wire rd_oevt = cmd_rd && cmd_sel == `SRH_SEL_OEVT;
	wire rd_esr = cmd_rd && cmd_sel == `SRH_SEL_ESR;
	wire rd_eq = cmd_rd && cmd_sel == `SRH_SEL_ERRQ && !eq_empty;
	// a push into a full queue is dropped; reading makes room first
	wire eq_push = err_push && (!eq_full || rd_eq);

	// generic registers: filters, enables, latched events
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q_prev_r <= `SRH_RST_ZERO16;
			o_prev_r <= `SRH_RST_ZERO16;
			q_rise_r <= `SRH_RST_RISE;
			o_rise_r <= `SRH_RST_RISE;
			q_fall_r <= `SRH_RST_ZERO16;
			o_fall_r <= `SRH_RST_ZERO16;
			q_evt_r <= `SRH_RST_ZERO16;
			o_evt_r <= `SRH_RST_ZERO16;
			q_ena_r <= `SRH_RST_ZERO16;
			o_ena_r <= `SRH_RST_ZERO16;
		end else if (ce) begin
			// edge history, per bit, same positions in all parts
			q_prev_r <= q_cond; // see R3
			o_prev_r <= o_cond; // see R3
			q_evt_r <= srh_evt_nxt(q_cond, q_prev_r, q_rise_r, q_fall_r,
				q_evt_r, rd_qevt); // see R8
			o_evt_r <= srh_evt_nxt(o_cond, o_prev_r, o_rise_r, o_fall_r,
				o_evt_r, rd_oevt); // see R8
			// writable parts; bit 15 is never stored
			if (cmd_wr) begin
				case (cmd_sel)
				`SRH_SEL_QRISE: q_rise_r <= cmd_wdata & `SRH_MASK15; // see R7
				`SRH_SEL_QFALL: q_fall_r <= cmd_wdata & `SRH_MASK15; // see R7
				`SRH_SEL_QENA: q_ena_r <= cmd_wdata & `SRH_MASK15; // see R7
				`SRH_SEL_ORISE: o_rise_r <= cmd_wdata & `SRH_MASK15; // see R7
				`SRH_SEL_OFALL: o_fall_r <= cmd_wdata & `SRH_MASK15; // see R7
				`SRH_SEL_OENA: o_ena_r <= cmd_wdata & `SRH_MASK15; // see R7
				default: begin
				end
				endcase
			end
		end
	end

	// standard event register, event enable, request mask
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			esr_r <= `SRH_RST_ZERO8;
			ese_r <= `SRH_RST_ZERO8;
			sre_r <= `SRH_RST_ZERO8;
		end else if (ce) begin
			// new event pulses win over a read clear
			esr_r <= (rd_esr ? `SRH_RST_ZERO8 : esr_r) | std_evt; // see R24
			if (cmd_wr && cmd_sel == `SRH_SEL_ESE)
				ese_r <= cmd_wdata[7:0]; // see R20
			if (cmd_wr && cmd_sel == `SRH_SEL_SRE)
				sre_r <= cmd_wdata[7:0]; // see R15
		end
	end

	// error queue, first in first out
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			eq_wp_r <= {EQ_AW{1'b0}};
			eq_rp_r <= {EQ_AW{1'b0}};
			eq_cnt_r <= {(EQ_AW+1){1'b0}};
		end else if (ce) begin
			if (eq_push)
				eq_wp_r <= eq_wp_r + 1'b1;
			if (rd_eq)
				eq_rp_r <= eq_rp_r + 1'b1; // see R19
			if (eq_push && !rd_eq)
				eq_cnt_r <= eq_cnt_r + 1'b1;
			else if (rd_eq && !eq_push)
				eq_cnt_r <= eq_cnt_r - 1'b1;
		end
	end

	// storage array has no reset; only written entries are ever read
	always @(posedge clk) begin
		if (ce && eq_push)
			eq_mem[eq_wp_r] <= err_code;
	end

	// service request on a masked rising byte bit
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stb_prev_r <= `SRH_RST_ZERO8;
			srq <= 1'b0;
		end else if (ce) begin
			stb_prev_r <= stb_low;
			// each error entry re-raises even if bit 2 already stood
			if (|(stb_low & ~stb_prev_r & sre_eff) ||
				(err_push && sre_eff[`SRH_B_ERR])) // see R14 R16
				srq <= 1'b1;
			else if (!rqs)
				srq <= 1'b0; // drops once nothing enabled stands
		end
	end

	// read data mux, registered one cycle after the strobe
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_rdata <= `SRH_RST_ZERO16;
			cmd_rvalid <= 1'b0;
			spoll_byte <= `SRH_RST_ZERO8;
			spoll_valid <= 1'b0;
		end else if (ce) begin
			cmd_rvalid <= cmd_rd;
			spoll_valid <= spoll;
			// serial poll gives the same byte as the query
			if (spoll)
				spoll_byte <= stb_full; // see R12
			if (cmd_rd) begin
				case (cmd_sel)
				`SRH_SEL_QCOND: cmd_rdata <= q_cond; // see R4
				`SRH_SEL_QRISE: cmd_rdata <= q_rise_r;
				`SRH_SEL_QFALL: cmd_rdata <= q_fall_r;
				`SRH_SEL_QEVT: cmd_rdata <= q_evt_r; // see R8
				`SRH_SEL_QENA: cmd_rdata <= q_ena_r;
				`SRH_SEL_OCOND: cmd_rdata <= o_cond; // see R4
				`SRH_SEL_ORISE: cmd_rdata <= o_rise_r;
				`SRH_SEL_OFALL: cmd_rdata <= o_fall_r;
				`SRH_SEL_OEVT: cmd_rdata <= o_evt_r;
				`SRH_SEL_OENA: cmd_rdata <= o_ena_r;
				`SRH_SEL_STB: cmd_rdata <= {8'h00, stb_full}; // see R12
				`SRH_SEL_SRE: cmd_rdata <= {8'h00, sre_r}; // see R15
				`SRH_SEL_ESR: cmd_rdata <= {8'h00, esr_r};
				`SRH_SEL_ESE: cmd_rdata <= {8'h00, ese_r};
				`SRH_SEL_ERRQ: begin
					// empty queue reads as zero
					if (eq_empty)
						cmd_rdata <= `SRH_RST_ZERO16;
					else
						cmd_rdata <= eq_mem[eq_rp_r]; // see R19
				end
				default: cmd_rdata <= `SRH_RST_ZERO16;
				endcase
			end
		end
	end

endmodule

//--- hw/srh_defines.vh
// constants for the status reporting hierarchy
`ifndef SRH_DEFINES_VH
`define SRH_DEFINES_VH
`define SRH_W 16
`define SRH_MASK15 16'h7fff
// register select codes on the command port
`define SRH_SEL_W 4
`define SRH_SEL_QCOND 4'h0
`define SRH_SEL_QRISE 4'h1
`define SRH_SEL_QFALL 4'h2
`define SRH_SEL_QEVT 4'h3
`define SRH_SEL_QENA 4'h4
`define SRH_SEL_OCOND 4'h5
`define SRH_SEL_ORISE 4'h6
`define SRH_SEL_OFALL 4'h7
`define SRH_SEL_OEVT 4'h8
`define SRH_SEL_OENA 4'h9
`define SRH_SEL_STB 4'ha
`define SRH_SEL_SRE 4'hb
`define SRH_SEL_ESR 4'hc
`define SRH_SEL_ESE 4'hd
`define SRH_SEL_ERRQ 4'he
// summary status byte bit positions
`define SRH_B_ERR 2
`define SRH_B_QUESTIONABLE_SUMMARY 3
`define SRH_B_MAV 4
`define SRH_B_ESB 5
`define SRH_B_RQS 6
`define SRH_B_OPERATION_SUMMARY 7
// reset values
`define SRH_RST_RISE 16'h7fff
`define SRH_RST_ZERO16 16'h0000
`define SRH_RST_ZERO8 8'h00
`define SRH_SRE_KEEP 8'hbc
`endif

//--- tb/srh_status_asserts.sv
// port checker for the status reporting hierarchy
`timescale 1ns/10ps
`include "srh_defines.vh"
module srh_status_asserts (
	// clock and reset
	input wire clk,
	input wire rstn,
	input wire ce,
	// sources and command port
	input wire [14:0] questionable_summary_src,
	input wire out_q_avail,
	input wire err_push,
	input wire cmd_rd,
	input wire [`SRH_SEL_W-1:0] cmd_sel,
	input wire [15:0] cmd_rdata,
	input wire cmd_rvalid,
	// poll side
	input wire spoll,
	input wire [7:0] spoll_byte,
	input wire spoll_valid,
	input wire srq,
	input wire err_q_nonempty
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// every read is answered on the next edge
	chk_rd_answer: assert property (ce && cmd_rd |=> cmd_rvalid)
		else $error("read not answered");
	chk_rd_bit15: assert property (cmd_rvalid |-> !cmd_rdata[15])
		else $error("bit 15 read as one");
	chk_poll_answer: assert property (ce && spoll |=> spoll_valid)
		else $error("poll not answered");
	chk_poll_unused: assert property (spoll_valid |-> spoll_byte[1:0] == 2'h0)
		else $error("unused byte bits set");
	// message bit only judged once the queue flag has settled
	chk_poll_msg: assert property (spoll_valid && $past(out_q_avail, 2)
		== out_q_avail && $past(out_q_avail) == out_q_avail
		|-> spoll_byte[4] == out_q_avail)
		else $error("message bit wrong");
	chk_err_flag: assert property (ce && err_push |=> err_q_nonempty)
		else $error("error entry lost");
	chk_err_empty: assert property (ce && cmd_rd && !err_push
		&& cmd_sel == `SRH_SEL_ERRQ && !err_q_nonempty
		|=> cmd_rdata == 16'h0000)
		else $error("empty queue read not zero");
	chk_live_read: assert property (ce && cmd_rd && $stable(questionable_summary_src)
		&& cmd_sel == `SRH_SEL_QCOND
		|=> cmd_rdata == {1'b0, $past(questionable_summary_src)})
		else $error("live state read wrong");
	cover property (spoll_valid && spoll_byte[6]);
	cover property (err_push ##1 srq);
	cover property (cmd_rvalid && cmd_rdata != 16'h0000);
endmodule

//--- tb/srh_host.sv
// host model: serial polls the device once per service request
`timescale 1ns/10ps
module srh_host (
	// clock and reset
	input wire clk,
	input wire rstn,
	// poll handshake
	input wire srq,
	output reg spoll,
	input wire [7:0] spoll_byte,
	input wire spoll_valid,
	// last byte seen
	output reg [7:0] poll_byte
);
	reg srq_r; // request seen last cycle
	// poll on the rise only, a level request would poll every cycle
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			srq_r <= 1'b0;
			spoll <= 1'b0;
			poll_byte <= 8'h00;
		end else begin
			srq_r <= srq;
			spoll <= srq && !srq_r;
			if (spoll_valid) begin
				poll_byte <= spoll_byte;
			end
		end
	end
endmodule

//--- tb/tb.sv
// self-checking bench for the status reporting hierarchy
`timescale 1ns/10ps
`include "srh_defines.vh"
`define CK(n,e,a) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
	// stimulus
	reg clk, rstn, out_q_avail, err_push, cmd_wr, cmd_rd;
	reg [14:0] questionable_summary_src, operation_summary_src;
	reg [7:0] std_evt;
	reg [15:0] err_code, cmd_wdata, v;
	reg [3:0] cmd_sel;
	// observed
	wire [15:0] cmd_rdata;
	wire [7:0] spoll_byte, pb;
	wire cmd_rvalid, spoll, spoll_valid, srq, err_q_nonempty;
	int fail_count, n_compared, cyc;
	srh_status srh_status_inst (.clk, .rstn, .ce(1'b1), .questionable_summary_src,
		.operation_summary_src, .std_evt, .out_q_avail, .err_push, .err_code, .cmd_wr,
		.cmd_rd, .cmd_sel, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .spoll,
		.spoll_byte, .spoll_valid, .srq, .err_q_nonempty);
	srh_host srh_host_inst (.clk, .rstn, .srq, .spoll, .spoll_byte,
		.spoll_valid, .poll_byte(pb));
	task print_verdict;
		if (fail_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task tick;
		@(posedge clk);
		#1;
	endtask
	// one-cycle write strobe
	task wr_r(input [3:0] s, input [15:0] d);
		cmd_sel = s;
		cmd_wdata = d;
		cmd_wr = 1'b1;
		tick;
		cmd_wr = 1'b0;
		tick;
	endtask
	// one-cycle read strobe, data kept in v
	task rd_r(input [3:0] s);
		cmd_sel = s;
		cmd_rd = 1'b1;
		tick;
		cmd_rd = 1'b0;
		v = cmd_rdata;
		`CK("rvalid", 1'b1, cmd_rvalid)
		tick;
	endtask
	task t_parts;
		rd_r(`SRH_SEL_QRISE); `CK("rise rst", 16'h7fff, v)
		rd_r(`SRH_SEL_QFALL); `CK("fall rst", 16'h0000, v)
		wr_r(`SRH_SEL_ORISE, 16'h8005);
		rd_r(`SRH_SEL_ORISE); `CK("rise wr", 16'h0005, v)
		rd_r(`SRH_SEL_ORISE); `CK("rise rd2", 16'h0005, v)
		wr_r(`SRH_SEL_ORISE, 16'h7fff);
	endtask
	task t_edges;
		wr_r(`SRH_SEL_QRISE, 16'h0001);
		wr_r(`SRH_SEL_QFALL, 16'h0002);
		questionable_summary_src = 15'h0003;
		repeat (3) tick;
		rd_r(`SRH_SEL_QCOND); `CK("cond", 16'h0003, v)
		rd_r(`SRH_SEL_QEVT); `CK("evt rise", 16'h0001, v)
		wr_r(`SRH_SEL_QEVT, 16'h7fff);
		rd_r(`SRH_SEL_QEVT); `CK("evt clr", 16'h0000, v)
		questionable_summary_src = 15'h0000;
		repeat (3) tick;
		rd_r(`SRH_SEL_QEVT); `CK("evt fall", 16'h0002, v)
	endtask
	task t_srq;
		wr_r(`SRH_SEL_QENA, 16'h0001);
		wr_r(`SRH_SEL_SRE, 16'h00ff);
		rd_r(`SRH_SEL_SRE); `CK("mask", 16'h00ff, v)
		questionable_summary_src = 15'h0001;
		for (int i = 0; i < 10 && srq !== 1'b1; i++) tick;
		`CK("srq", 1'b1, srq)
		repeat (4) tick;
		`CK("poll questionable_summary", 1'b1, pb[3])
		`CK("poll rqs", 1'b1, pb[6])
		rd_r(`SRH_SEL_QEVT);
		repeat (4) tick;
		`CK("srq drop", 1'b0, srq)
	endtask
	task t_err;
		err_push = 1'b1;
		err_code = 16'h0011;
		tick;
		err_code = 16'h0022;
		tick;
		err_push = 1'b0;
		repeat (2) tick;
		rd_r(`SRH_SEL_STB); `CK("err bit", 1'b1, v[2])
		rd_r(`SRH_SEL_ERRQ); `CK("err 1st", 16'h0011, v)
		rd_r(`SRH_SEL_ERRQ); `CK("err 2nd", 16'h0022, v)
		`CK("err empty", 1'b0, err_q_nonempty)
	endtask
	task t_byte;
		out_q_avail = 1'b1;
		std_evt = 8'h01;
		tick;
		std_evt = 8'h00;
		operation_summary_src = 15'h0001;
		wr_r(`SRH_SEL_ESE, 16'h0001);
		wr_r(`SRH_SEL_OENA, 16'h0001);
		repeat (3) tick;
		rd_r(`SRH_SEL_STB); `CK("byte hi", 4'hf, v[7:4])
		out_q_avail = 1'b0;
		repeat (3) tick;
		rd_r(`SRH_SEL_STB); `CK("msg off", 1'b0, v[4])
		rd_r(`SRH_SEL_ESR); `CK("std evt", 16'h0001, v)
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			print_verdict;
		end
	end
	initial begin
		{rstn, out_q_avail, err_push, cmd_wr, cmd_rd} = 5'h00;
		{questionable_summary_src, operation_summary_src, std_evt} = 38'h0;
		{err_code, cmd_wdata, cmd_sel} = 36'h0;
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		t_parts;
		t_edges;
		t_srq;
		t_err;
		t_byte;
		print_verdict;
	end
endmodule
bind srh_status srh_status_asserts srh_status_asserts_inst (.clk, .rstn,
	.ce, .questionable_summary_src, .out_q_avail, .err_push, .cmd_rd, .cmd_sel, .cmd_rdata,
	.cmd_rvalid, .spoll, .spoll_byte, .spoll_valid, .srq, .err_q_nonempty);
